// ### verilog/rpc_pkg.sv
// Constants and carrier types for the external reset pin controller.
// Assumes one system clock at 200 MHz; the pin is open drain with pull-up.
package rpc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ    = 200_000_000;
    // Default oscillator stabilisation wait in microseconds
    localparam int unsigned OSC_WAIT_US    = 100;
    localparam int unsigned OSC_WAIT_CYC   =
        (OSC_WAIT_US * (CLK_FREQ_HZ / 1_000_000));
    // Least low time driven out on a self-made reset, nanoseconds
    localparam int unsigned PULL_LOW_NS    = 1000;
    localparam int unsigned PULL_LOW_CYC   =
        (PULL_LOW_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

    // ------------------------------------------------------------
    // Reset values and sync stage count
    // ------------------------------------------------------------
    localparam logic        SHARED_BIT_RST = 1'h1;
    localparam int unsigned SYNC_STAGES    = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RPC_ST_HELD,
        RPC_ST_WAIT,
        RPC_ST_RUN,
        RPC_ST_PULL
    } rpc_state_e;

    // Reset requests coming from inside the chip
    typedef struct packed {
        logic port_wr;
        logic port_val;
        logic wdt_ovf;
    } rpc_req_s;

    // Status reported to the core
    typedef struct packed {
        logic core_rst_n;
        logic rst_int_start;
        logic pin_level;
        logic shared_bit;
    } rpc_stat_s;

endpackage

// ### verilog/rpc_reset_pin.sv
// Reset pin controller: synchronises the external reset pin, waits for
// oscillator stabilisation, and pulls the pin low on internal resets.
// Assumes an external pull-up on the pin and core logic on CLK_SYS_I.
// Clock enable low freezes every register, the synchroniser included.
// Internal reset requests are one-cycle pulses from the core.
// OSC_WAIT_CYC must be at least one.
`timescale 1ns/100ps
module rpc_reset_pin #(
    parameter int unsigned OSC_WAIT_CYC = rpc_pkg::OSC_WAIT_CYC
) (
    // Clock, reset, enable
    input  wire logic              CLK_SYS_I,
    input  wire logic              RST_N_I,
    input  wire logic              CE_I,
    // Reset pin, open drain
    input  wire logic              RST_PIN_I,
    output logic                   RST_PIN_O,
    output logic                   RST_PIN_OE_N_O,
    // Requests from core
    input  wire rpc_pkg::rpc_req_s REQ_I,
    // Status to core
    output rpc_pkg::rpc_stat_s     STAT_O
);


    // ------------------------------------------------------------
    // Derived sizes
    // ------------------------------------------------------------
    // Counters sized to reach their last value without wrapping
    // Pull low time is fixed; the wait may differ per instance
    localparam int CW = $clog2(OSC_WAIT_CYC + 1);
    localparam int PW = $clog2(rpc_pkg::PULL_LOW_CYC + 1);
    localparam logic [CW-1:0] WAIT_LAST = CW'(OSC_WAIT_CYC - 1);
    localparam logic [PW-1:0] PULL_LAST = PW'(rpc_pkg::PULL_LOW_CYC - 1);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    rpc_pkg::rpc_state_e state_q;
    logic [2:0]          pin_sync_q;
    logic                pin_lvl_q;
    logic                pin_agree;
    logic                shared_bit_q;
    logic                sw_rst;
    logic                self_rst;
    logic [CW-1:0]       wait_q;
    logic [PW-1:0]       pull_q;
    logic                wait_done;
    logic                pull_done;
    logic                pin_pull;
    logic                int_start_q;

    // ------------------------------------------------------------
    // State decode
    // ------------------------------------------------------------
    // Core may run only in this state
    function automatic logic is_run(rpc_pkg::rpc_state_e st);
        return st == rpc_pkg::RPC_ST_RUN;
    endfunction

    function automatic logic is_wait(rpc_pkg::rpc_state_e st);
        return st == rpc_pkg::RPC_ST_WAIT;
    endfunction

    function automatic logic is_pull(rpc_pkg::rpc_state_e st);
        return st == rpc_pkg::RPC_ST_PULL;
    endfunction

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Three-stage sync
    // Reset low so the first release is always seen as a rise
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_sync_q <= 3'h0;
        end else if (CE_I) begin
            pin_sync_q <= {pin_sync_q[1:0], RST_PIN_I};
        end
    end

    // One-cycle pin glitches never reach both late stages together
    assign pin_agree = (pin_sync_q[1] == pin_sync_q[2]);

    // Level taken once stages two and three agree
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_lvl_q <= 1'h0;
        end else if (CE_I && pin_agree) begin
            pin_lvl_q <= pin_sync_q[2];
        end
    end

    // ------------------------------------------------------------
    // Internal reset requests
    // ------------------------------------------------------------
    // Zero written to the shared port bit
    assign sw_rst   = REQ_I.port_wr && !REQ_I.port_val;

    // Requests only count while the core runs
    assign self_rst = is_run(state_q) && (sw_rst || REQ_I.wdt_ovf);

    // ------------------------------------------------------------
    // Shared port bit
    // ------------------------------------------------------------
    // Writing 1 only stores the value
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            shared_bit_q <= rpc_pkg::SHARED_BIT_RST;
        end else if (CE_I) begin
            if (!is_run(state_q)) begin
                shared_bit_q <= rpc_pkg::SHARED_BIT_RST;
            end else if (REQ_I.port_wr) begin
                shared_bit_q <= REQ_I.port_val;
            end
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    // Last cycle of the oscillator wait
    // Decoded once, shared by sequencer and start pulse
    assign wait_done = is_wait(state_q) && pin_lvl_q
                       && (wait_q == WAIT_LAST);
    assign pull_done = is_pull(state_q) && (pull_q == PULL_LAST);

    // Wait restarts from zero on every entry
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wait_q <= '0;
        end else if (CE_I) begin
            if (is_wait(state_q)) begin
                wait_q <= wait_q + CW'(1);
            end else begin
                wait_q <= '0;
            end
        end
    end

    // Low time of a self-made pull
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pull_q <= '0;
        end else if (CE_I) begin
            if (is_pull(state_q)) begin
                pull_q <= pull_q + PW'(1);
            end else begin
                pull_q <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= rpc_pkg::RPC_ST_HELD;
        end else if (CE_I) begin
            unique case (state_q)
                rpc_pkg::RPC_ST_HELD: begin
                    if (pin_lvl_q) begin
                        state_q <= rpc_pkg::RPC_ST_WAIT;
                    end
                end
                rpc_pkg::RPC_ST_WAIT: begin
                    if (!pin_lvl_q) begin
                        state_q <= rpc_pkg::RPC_ST_HELD;
                    end else if (wait_done) begin
                        state_q <= rpc_pkg::RPC_ST_RUN;
                    end
                end
                rpc_pkg::RPC_ST_RUN: begin
                    // Internal reset sources
                    // Self reset wins over a pin falling the same cycle
                    if (self_rst) begin
                        state_q <= rpc_pkg::RPC_ST_PULL;
                    end else if (!pin_lvl_q) begin
                        state_q <= rpc_pkg::RPC_ST_HELD;
                    end
                end
                rpc_pkg::RPC_ST_PULL: begin
                    // Pin read back low is held until release
                    if (pull_done) begin
                        state_q <= rpc_pkg::RPC_ST_HELD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            int_start_q <= 1'h0;
        end else if (CE_I) begin
            int_start_q <= wait_done;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open drain, low only
    assign RST_PIN_O      = 1'b0;
    // Pin also pulled low while the port bit holds 0
    assign pin_pull       = is_pull(state_q) || !shared_bit_q;
    assign RST_PIN_OE_N_O = !pin_pull;

    assign STAT_O.core_rst_n    = is_run(state_q);
    assign STAT_O.rst_int_start = int_start_q;
    assign STAT_O.pin_level     = pin_lvl_q;
    assign STAT_O.shared_bit    = shared_bit_q;

endmodule

// ### testbench/rpc_ext_rst.sv
// External reset source: pull-up on the pin plus a circuit that can
// hold it low. Assumes the chip pulls low through its enable only.
`timescale 1ns/100ps
module rpc_ext_rst (
    // From the bench
    input  wire logic hold_i,
    // Chip side of the pin
    input  wire logic chip_val_i,
    input  wire logic chip_oe_n_i,
    output logic      pin_o
);
    // Released pin floats to the pull-up level, never to a stale value
    assign pin_o = hold_i ? 1'b0 : (!chip_oe_n_i ? chip_val_i : 1'b1);
endmodule

// ### testbench/rpc_reset_pin_sva.sv
// Checker for the reset pin controller, bound to its ports.
// Assumes the wait parameter is the one given to the design.
`timescale 1ns/100ps
module rpc_reset_pin_sva #(
    parameter int unsigned OSC_WAIT_CYC = 8
) (
    input wire logic               CLK_SYS_I,
    input wire logic               RST_N_I,
    input wire logic               CE_I,
    input wire logic               RST_PIN_I,
    input wire logic               RST_PIN_O,
    input wire logic               RST_PIN_OE_N_O,
    input wire rpc_pkg::rpc_req_s  REQ_I,
    input wire rpc_pkg::rpc_stat_s STAT_O
);
    localparam int WM = OSC_WAIT_CYC;
    wire logic run = STAT_O.core_rst_n;
    wire logic oe  = RST_PIN_OE_N_O;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    chk_held_core: assert property (!STAT_O.pin_level |=> !run)
        else $error("core running while pin low");
    chk_wait_len: assert property ($rose(STAT_O.pin_level) |->
        ##WM !run ##1 run) else $error("wait length wrong");
    chk_int_at_run: assert property ($rose(run) |->
        STAT_O.rst_int_start) else $error("no interrupt start");
    chk_int_pulse: assert property (STAT_O.rst_int_start |=>
        !STAT_O.rst_int_start) else $error("start not one cycle");
    chk_sw_pull: assert property (run && CE_I && REQ_I.port_wr &&
        !REQ_I.port_val |=> !oe && !run) else $error("no soft reset");
    chk_wdt_pull: assert property (run && CE_I && REQ_I.wdt_ovf |=>
        !oe && !run) else $error("no watchdog reset");
    chk_pin_low_only: assert property (RST_PIN_O == 1'b0)
        else $error("pin driven high");
    chk_pull_len: assert property ($fell(oe) |-> ##199 !oe ##1 oe)
        else $error("pull length wrong");
    cover property ($rose(run));
    cover property (run && REQ_I.wdt_ovf);
    cover property (run && REQ_I.port_wr && !REQ_I.port_val);
endmodule
bind rpc_reset_pin rpc_reset_pin_sva #(.OSC_WAIT_CYC(OSC_WAIT_CYC)) u_sva (
    .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
    .RST_PIN_I(RST_PIN_I), .RST_PIN_O(RST_PIN_O),
    .RST_PIN_OE_N_O(RST_PIN_OE_N_O), .REQ_I(REQ_I), .STAT_O(STAT_O));

// ### testbench/tb.sv
// Bench for the reset pin controller with an external reset source.
// Assumes a short oscillator wait of 8 cycles.
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
    $display("BAD %s exp %h got %h", n, e, s); fails++; end end
module tb;
    logic               clk = 0, rst_n = 0, hold = 1, ce = 1;
    logic               pin, oe_n, pin_o;
    rpc_pkg::rpc_req_s  req = '0;
    rpc_pkg::rpc_stat_s stat;
    int                 fails = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    rpc_reset_pin #(.OSC_WAIT_CYC(8)) dut (.CLK_SYS_I(clk),
        .RST_N_I(rst_n), .CE_I(ce), .RST_PIN_I(pin), .RST_PIN_O(pin_o),
        .RST_PIN_OE_N_O(oe_n), .REQ_I(req), .STAT_O(stat));
    rpc_ext_rst ext (.hold_i(hold), .chip_val_i(pin_o),
        .chip_oe_n_i(oe_n), .pin_o(pin));
    task automatic finish_test();
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic drive(logic h, rpc_pkg::rpc_req_s r);
        @(posedge clk) hold <= h;
        req <= r;
        @(posedge clk) req <= '0;
        #1;
    endtask
    task automatic wait_run();
        int i;
        for (i = 0; i < 600 && stat.core_rst_n !== 1'b1; i++) begin
            @(posedge clk) hold <= 1'b0;
            #1;
        end
        if (i == 600) begin fails++; finish_test(); end
        `CHK("int_start", 1'b1, stat.rst_int_start)
        @(posedge clk) #1;
        `CHK("int_end", 1'b0, stat.rst_int_start)
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        drive(1, '0);
        drive(1, 3'h1);
        `CHK("held_core", 1'b0, stat.core_rst_n)
        `CHK("held_oe", 1'b1, oe_n)
        `CHK("shared_rst", 1'b1, stat.shared_bit)
        wait_run();
        drive(0, 3'h6);
        `CHK("wr1_run", 1'b1, stat.core_rst_n)
        drive(0, 3'h4);
        `CHK("sw_oe", 1'b0, oe_n)
        `CHK("sw_core", 1'b0, stat.core_rst_n)
        `CHK("sw_pin", 1'b0, pin)
        `CHK("pin_val", 1'b0, pin_o)
        wait_run();
        drive(0, 3'h1);
        `CHK("wdt_oe", 1'b0, oe_n)
        `CHK("wdt_core", 1'b0, stat.core_rst_n)
        wait_run();
        @(posedge clk) ce <= 1'b0;
        drive(0, 3'h1);
        `CHK("ce_core", 1'b1, stat.core_rst_n)
        `CHK("ce_oe", 1'b1, oe_n)
        @(posedge clk) ce <= 1'b1;
        @(posedge clk) hold <= 1'b1;
        @(posedge clk) hold <= 1'b0;
        repeat (3) drive(0, '0);
        `CHK("glitch", 1'b1, stat.core_rst_n)
        repeat (3) drive(1, '0);
        `CHK("ext_core", 1'b0, stat.core_rst_n)
        wait_run();
        finish_test();
    end
endmodule
